// file: tpo_map.svh
// register offsets, field positions, reset values and timing counts
// of the tank pump-out sequencer; definitions only
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define TPO_ADDR_W          4
`define TPO_ADDR_CTRL       4'h0
`define TPO_ADDR_STATUS     4'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TPO_CTRL_RUN        0
`define TPO_STAT_STATE_LO   0
`define TPO_STAT_LAMP       3
`define TPO_STAT_N2         4
`define TPO_STAT_OUTLET     5
`define TPO_STAT_PUMP       6
`define TPO_STAT_VENT_OK    7
`define TPO_STAT_HOLD_DONE  8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TPO_CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TPO_MCLK_KHZ        50000
`define TPO_END_HOLD_MS     8000
`define TPO_END_HOLD_CYCLES (`TPO_END_HOLD_MS * `TPO_MCLK_KHZ)

`endif

// file: tpo_pkg.sv
// types shared by the tank pump-out sequencer files
// assumes nothing of its surroundings
package tpo_pkg;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TPO_IDLE    = 3'b000,
      TPO_RECOVER = 3'b001,
      TPO_VENT    = 3'b010,
      TPO_CHECK   = 3'b011,
      TPO_PRESS   = 3'b100,
      TPO_PUMP    = 3'b101
   } tpo_state_t;

   // ----------------------------------------------------------------
   // actuator group, always switched off together
   // ----------------------------------------------------------------
   typedef struct packed {
      logic nitrogen_supply_valve;
      logic outlet_valve;
      logic liquid_pump;
   } tpo_act_t;

   // ----------------------------------------------------------------
   // tank and source sensor group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tank_mid_level;
      logic tank_low_level;
      logic source_vacuum_ok;
      logic pressure_alarm_one;
      logic pressure_alarm_two;
      logic pumpout_end_level;
   } tpo_sense_t;

endpackage : tpo_pkg

// file: tpo_hold_timer.sv
// persistence timer: reports once a condition has held for HOLD cycles
// assumes cond is synchronous to mclk
module tpo_hold_timer #(
   parameter int unsigned HOLD = 400000000
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // condition watched and its verdict
   input  wire logic run,
   input  wire logic cond,
   output logic      done
);

   localparam int W = $clog2(HOLD + 1);

   // refuse a hold the counter cannot represent; HOLD + 1 must not wrap
   if (HOLD < 1 || HOLD > 32'h7fff_ffff) begin : g_bad_hold
      $error("tpo_hold_timer: HOLD must be 1 to 2147483647");
   end

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_done;

   // restart whenever the condition drops; saturate once reached
   always_comb begin
      next_count = count;
      next_done  = 1'b0;
      if (!run || !cond) begin
         next_count = '0;
      end else if (count != W'(HOLD)) begin
         next_count = count + W'(1);
      end
      next_done = run && cond && (next_count == W'(HOLD));
   end

   // register only
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         count <= '0;
         done  <= 1'b0;
      end else begin
         count <= next_count;
         done  <= next_done;
      end
   end

endmodule : tpo_hold_timer

// file: tpo_sequencer.sv
// tank pump-out sequencer: final vent check, pressurise, pump, end
// assumes synchronous sensor inputs and a one-cycle strobe register port
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "tpo_map.svh"

module tpo_sequencer #(
   parameter int unsigned END_HOLD_CYCLES = `TPO_END_HOLD_CYCLES
) (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   // register port
   input  wire logic [`TPO_ADDR_W-1:0]      reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [31:0]                 reg_rdata,
   // tank and source sensors
   input  wire tpo_pkg::tpo_sense_t         sense,
   // final vent handshake with the vent sequencer
   input  wire logic                        final_vent_active_in,
   // actuators and lamp
   output tpo_pkg::tpo_act_t                act,
   output logic                             processing_lamp_out,
   // requests to the recovery and cooling logic
   output logic                             recovery_active_out,
   output logic                             extra_cycle_req_out
);

   // ----------------------------------------------------------------
   // checks on parameters
   // ----------------------------------------------------------------
   // a zero or wrapping hold would end pump-out at once
   if (END_HOLD_CYCLES < 1 || END_HOLD_CYCLES > 32'h7fff_ffff) begin : g_bad_hold
      $error("tpo_sequencer: END_HOLD_CYCLES must be 1 to 2147483647");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic                ctrl_run;
   logic                next_ctrl_run;
   logic [31:0]         next_rdata;
   tpo_pkg::tpo_state_t state;
   tpo_pkg::tpo_state_t next_state;
   tpo_pkg::tpo_act_t   next_act;
   logic                next_lamp;
   logic                vent_ok;
   logic                next_vent_ok;
   logic                next_recovery;
   logic                next_extra;
   logic                hold_done;

   // tank qualifies for pump-out
   function automatic logic qualifies(input tpo_pkg::tpo_sense_t s);
      qualifies = s.tank_mid_level ||
                  (!s.source_vacuum_ok && s.tank_low_level);
   endfunction : qualifies

   // ----------------------------------------------------------------
   // low-level persistence timer
   // ----------------------------------------------------------------
   tpo_hold_timer #(
      .HOLD (END_HOLD_CYCLES)
   ) u_hold (
      .mclk  (mclk),
      .rst_b (rst_b),
      .run   (state == tpo_pkg::TPO_PUMP),
      .cond  (!sense.tank_low_level),
      .done  (hold_done)
   );

   // register port: control write, status read one cycle later
   always_comb begin
      next_ctrl_run = ctrl_run;
      next_rdata    = 32'h0000_0000;
      if (reg_wr && reg_addr == `TPO_ADDR_CTRL) begin
         next_ctrl_run = reg_wdata[`TPO_CTRL_RUN];
      end
      // an automatic stop drops run, so idle holds until software restarts it
      if (state == tpo_pkg::TPO_PUMP && hold_done && !sense.pumpout_end_level &&
          !sense.tank_low_level && !sense.source_vacuum_ok) begin
         next_ctrl_run = 1'b0;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `TPO_ADDR_CTRL: begin
               next_rdata[`TPO_CTRL_RUN] = ctrl_run;
            end
            `TPO_ADDR_STATUS: begin
               next_rdata[`TPO_STAT_STATE_LO +: 3] = state;
               next_rdata[`TPO_STAT_LAMP]          = processing_lamp_out;
               next_rdata[`TPO_STAT_N2]            = act.nitrogen_supply_valve;
               next_rdata[`TPO_STAT_OUTLET]        = act.outlet_valve;
               next_rdata[`TPO_STAT_PUMP]          = act.liquid_pump;
               next_rdata[`TPO_STAT_VENT_OK]       = vent_ok;
               next_rdata[`TPO_STAT_HOLD_DONE]     = hold_done;
            end
            default: begin
               next_rdata = 32'h0000_0000;                         // unmapped reads zero
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_run  <= 1'(`TPO_CTRL_RESET);
         reg_rdata <= 32'h0000_0000;
      end else begin
         ctrl_run  <= next_ctrl_run;
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // outputs follow next_state so all actuators change in one edge
   always_comb begin
      next_state   = state;
      next_vent_ok = vent_ok;
      next_extra   = 1'b0;
      unique case (state)
         tpo_pkg::TPO_IDLE: begin
            if (ctrl_run) begin
               next_state = tpo_pkg::TPO_RECOVER;
            end
         end
         tpo_pkg::TPO_RECOVER: begin
            if (final_vent_active_in) begin
               next_state = tpo_pkg::TPO_VENT;
            end
         end
         tpo_pkg::TPO_VENT: begin
            if (!sense.pressure_alarm_two) begin
               next_vent_ok = 1'b1;
               next_state   = tpo_pkg::TPO_CHECK;
            end
         end
         tpo_pkg::TPO_CHECK: begin
            next_vent_ok = 1'b0;
            if (vent_ok && sense.tank_low_level && qualifies(sense)) begin
               next_state = tpo_pkg::TPO_PRESS;
            end else begin
               next_extra = 1'b1;
               next_state = tpo_pkg::TPO_RECOVER;
            end
         end
         tpo_pkg::TPO_PRESS: begin
            if (!sense.pressure_alarm_one) begin
               next_state = tpo_pkg::TPO_PUMP;
            end
         end
         tpo_pkg::TPO_PUMP: begin
            // both the local hold count and the end input must agree
            if (hold_done && !sense.pumpout_end_level) begin
               if (!sense.tank_low_level && !sense.source_vacuum_ok) begin
                  next_state = tpo_pkg::TPO_IDLE;
               end else begin
                  next_state = tpo_pkg::TPO_RECOVER;
               end
            end
         end
         default: begin
            next_state = tpo_pkg::TPO_IDLE;                        // illegal codes recover
         end
      endcase
      // software stop overrides everything, actuators off at once
      if (!ctrl_run) begin
         next_state   = tpo_pkg::TPO_IDLE;
         next_vent_ok = 1'b0;
         next_extra   = 1'b0;
      end
      next_act.nitrogen_supply_valve = (next_state == tpo_pkg::TPO_PRESS) ||
                                       (next_state == tpo_pkg::TPO_PUMP);
      next_act.outlet_valve          = (next_state == tpo_pkg::TPO_PUMP);
      next_act.liquid_pump           = (next_state == tpo_pkg::TPO_PUMP);
      next_lamp                      = (next_state != tpo_pkg::TPO_IDLE);
      next_recovery                  = (next_state == tpo_pkg::TPO_RECOVER);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state               <= tpo_pkg::TPO_IDLE;
         vent_ok             <= 1'b0;
         act                 <= '0;
         processing_lamp_out <= 1'b0;
         recovery_active_out <= 1'b0;
         extra_cycle_req_out <= 1'b0;
      end else begin
         state               <= next_state;
         vent_ok             <= next_vent_ok;
         act                 <= next_act;
         processing_lamp_out <= next_lamp;
         recovery_active_out <= next_recovery;
         extra_cycle_req_out <= next_extra;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_press_start;
      state == tpo_pkg::TPO_CHECK && ctrl_run && vent_ok && sense.tank_low_level
         && qualifies(sense);
   endsequence

   sequence s_pump_end;
      state == tpo_pkg::TPO_PUMP && ctrl_run && hold_done && !sense.pumpout_end_level;
   endsequence

   a_start_needs_vent: assert property (
      $rose(act.nitrogen_supply_valve) |-> $past(vent_ok) && $past(qualifies(sense)))
      else $error("pump-out began without a qualified final vent");

   a_n2_on_start: assert property (
      s_press_start |=> act.nitrogen_supply_valve && !act.liquid_pump)
      else $error("nitrogen valve not opened at pump-out start");

   a_pump_on_alarm: assert property (
      state == tpo_pkg::TPO_PRESS && ctrl_run && !sense.pressure_alarm_one
         |=> act.outlet_valve && act.liquid_pump)
      else $error("outlet and pump not started above alarm one");

   a_pump_needs_pres: assert property (
      $rose(act.liquid_pump) |-> $past(!sense.pressure_alarm_one) && $past(act.nitrogen_supply_valve))
      else $error("pump started before tank pressurised");

   a_end_needs_hold: assert property (
      $fell(act.liquid_pump) && $past(ctrl_run) |-> $past(hold_done) && $past(!sense.pumpout_end_level))
      else $error("pump-out ended before low-level hold");

   a_stop_lamp_off: assert property (
      s_pump_end ##0 (!sense.tank_low_level && !sense.source_vacuum_ok)
         |=> !processing_lamp_out ##1 state == tpo_pkg::TPO_IDLE)
      else $error("processing not stopped with lamp off");

   a_resume_recovery: assert property (
      s_pump_end ##0 sense.source_vacuum_ok
         |=> processing_lamp_out && recovery_active_out)
      else $error("recovery not resumed with lamp on");

   a_extra_cycle: assert property (
      state == tpo_pkg::TPO_CHECK && ctrl_run && !(vent_ok && sense.tank_low_level
         && qualifies(sense)) |=> extra_cycle_req_out ##1 !extra_cycle_req_out)
      else $error("no further cycle request after unqualified vent");

   a_vent_done: assert property (
      state == tpo_pkg::TPO_VENT && ctrl_run && !sense.pressure_alarm_two
         |=> vent_ok && state == tpo_pkg::TPO_CHECK)
      else $error("final vent completion not taken");

   a_all_off_together: assert property (
      $fell(act.nitrogen_supply_valve) |-> !act.outlet_valve && !act.liquid_pump)
      else $error("actuators not switched off together");

endmodule : tpo_sequencer

// file: tpo_tank_model.sv
// partner model: tank pressure switch and end-of-pump-out level switch
// assumes actuator levels from the sequencer and a tank low level from the bench
module tpo_tank_model #(
   parameter int unsigned END_DELAY = 1
) (
   // clock
   input  wire logic              mclk,
   // actuators seen and bench controls
   input  wire tpo_pkg::tpo_act_t act,
   input  wire logic              tank_low_level,
   input  wire logic [7:0]        press_delay,
   // switch outputs
   output logic                   pressure_alarm_one,
   output logic                   pumpout_end_level
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned press_cnt = 0;
   int unsigned low_cnt   = 0;

   // ----------------------------------------------------------------
   // tank physics
   // ----------------------------------------------------------------
   // pressure rises only while nitrogen flows and collapses when it shuts
   // no manual override path: pumps run only under the sequencer's short hold
   always @(posedge mclk) begin
      press_cnt <= act.nitrogen_supply_valve ? press_cnt + 1 : 0;
      low_cnt   <= tank_low_level ? 0 : low_cnt + 1;
   end

   // press_delay makes the tank prompt or slow to pressurise
   assign pressure_alarm_one = (press_cnt <= press_delay);
   // end switch trails the low switch, so the sequencer's own count decides
   assign pumpout_end_level  = (low_cnt < END_DELAY);
endmodule : tpo_tank_model

// file: tpo_sequencer_tb.sv
// self-checking bench for the tank pump-out sequencer
// assumes a 50 MHz mclk, synchronous active-low reset, tank model as far side
`include "tpo_map.svh"

module tpo_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned HOLD = 4;

   logic                 mclk, rst_b, reg_wr, reg_rd;
   logic [3:0]           reg_addr;
   logic [31:0]          reg_wdata, reg_rdata, rdv;
   logic                 mid, low, vac, alarm_two, vent_in, alarm_one, end_lvl;
   logic                 lamp, recov, extra, qual;
   logic [7:0]           press_delay;
   tpo_pkg::tpo_act_t    act;
   tpo_pkg::tpo_sense_t  sense;
   int                   bad_count = 0, comparisons = 0, cycles = 0, n;

   assign sense = {mid, low, vac, alarm_one, alarm_two, end_lvl};

   tpo_sequencer #(.END_HOLD_CYCLES(HOLD)) dut (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense(sense),
      .final_vent_active_in(vent_in), .act(act), .processing_lamp_out(lamp),
      .recovery_active_out(recov), .extra_cycle_req_out(extra));

   tpo_tank_model #(.END_DELAY(1)) tank (
      .mclk(mclk), .act(act), .tank_low_level(low), .press_delay(press_delay),
      .pressure_alarm_one(alarm_one), .pumpout_end_level(end_lvl));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic go_pump(input logic m, l, v);
      return l && (m || !v);
   endfunction : go_pump

   function automatic logic [31:0] exp_status(input logic [2:0] st, input logic lp,
                                              input logic [2:0] a);
      return {25'h0, a[0], a[1], a[2], lp, st};
   endfunction : exp_status

   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // bus tasks start just after a rising edge and end just after one
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      rdv = reg_rdata;
      @(posedge mclk);
   endtask : rd_reg

   // waits for act to reach exp; anything but from meanwhile is a fault
   task automatic wait_act(input logic [2:0] exp, from, input int lim);
      n = 0;
      @(negedge mclk);
      while (act !== exp && n < lim) begin
         check("act between steps", act, from);
         @(negedge mclk);
         n++;
      end
      check("act", act, exp);
   endtask : wait_act

   task automatic wrap_up;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      {mid, low, vac, alarm_two, vent_in} = 5'h0a;
      press_delay = 8'h03;
      void'($urandom(32'hf763));
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd_reg(`TPO_ADDR_CTRL);
      check("ctrl reset", rdv, `TPO_CTRL_RESET);
      rd_reg(4'h8);
      check("unmapped read", rdv, 32'h0);
      // sensor noise while stopped must never start anything
      for (int i = 0; i < 8; i++) begin
         {mid, low, vac, alarm_two, vent_in} <= 5'($urandom);
         @(posedge mclk);
      end
      wr_reg(`TPO_ADDR_STATUS, 32'hffff_ffff);
      rd_reg(`TPO_ADDR_STATUS);
      check("status stopped", rdv & 32'h7f, 32'h0);
      {mid, low, vac, alarm_two, vent_in} <= 5'h0a;
      wr_reg(`TPO_ADDR_CTRL, 32'h1);
      @(negedge mclk);
      check("lamp on run", lamp, 1'b1);
      check("recovery on run", recov, 1'b1);
      @(posedge mclk);
      // case 0 never qualifies, 1 qualifies on mid level, 2 on lost vacuum plus low
      for (int c = 0; c < 3; c++) begin
         mid <= (c == 0) ? 1'($urandom) : (c == 1);
         low <= (c != 0);
         vac <= (c == 0) ? 1'($urandom) : (c == 1);
         press_delay <= 8'($urandom_range(12, 1));
         @(posedge mclk);
         qual = go_pump(mid, low, vac);
         vent_in <= 1'b1;
         alarm_two <= 1'b0;
         if (!qual) begin
            n = 0;
            @(negedge mclk);
            while (extra !== 1'b1 && n < 6) begin
               @(negedge mclk);
               n++;
            end
            check("extra request", extra, 1'b1);
            check("back to recovery", recov, 1'b1);
            check("no pump-out", act, 3'b000);
            @(posedge mclk);
            vent_in <= 1'b0;
            alarm_two <= 1'b1;
            @(negedge mclk);
            check("extra one cycle", extra, 1'b0);
            @(posedge mclk);
         end else begin
            wait_act(3'b100, 3'b000, 6);
            @(posedge mclk);
            vent_in <= 1'b0;
            alarm_two <= 1'b1;
            wait_act(3'b111, 3'b100, press_delay + 4);
            @(posedge mclk);
            rd_reg(`TPO_ADDR_STATUS);
            check("status pumping", rdv & 32'h7f,
                  exp_status(tpo_pkg::TPO_PUMP, 1'b1, 3'b111));
            // a brief return of liquid must restart the low-level count
            low <= 1'b0;
            repeat (HOLD - 1) @(posedge mclk);
            low <= 1'b1;
            @(posedge mclk);
            low <= 1'b0;
            wait_act(3'b000, 3'b111, HOLD + 3);
            check("hold restarted", 32'(n >= HOLD), 32'h1);
            check("lamp after end", lamp, c == 1);
            check("recovery after end", recov, c == 1);
            @(posedge mclk);
            if (c == 1) begin
               rd_reg(`TPO_ADDR_STATUS);
               check("status recovery", rdv & 32'h7f,
                     exp_status(tpo_pkg::TPO_RECOVER, 1'b1, 3'b000));
            end
         end
      end
      // the last case stopped on its own: run must have dropped and idle must hold
      rd_reg(`TPO_ADDR_CTRL);
      check("run cleared on stop", rdv, 32'h0);
      rd_reg(`TPO_ADDR_STATUS);
      check("status idle after stop", rdv & 32'h7f,
            exp_status(tpo_pkg::TPO_IDLE, 1'b0, 3'b000));
      wr_reg(`TPO_ADDR_CTRL, 32'h0);
      @(negedge mclk);
      check("lamp after stop", lamp, 1'b0);
      @(posedge mclk);
      rd_reg(`TPO_ADDR_CTRL);
      check("ctrl cleared", rdv, 32'h0);
      wrap_up();
   end
endmodule : tpo_sequencer_tb
